// [core/pcsc_clock_ctrl.sv]
// Clock generation and system control: post-divider, PLL lock tracking,
// missing-oscillator detection, clock gates, wake select and map bit.
// Assumes oscillator pins are asynchronous and software writes arrive as
// one-cycle strobes on clk_sys with data valid in the same cycle.
// Overview of operation
// [R1] Post-divider divides PLL output by one, two or four.
// [R2] Post-divider select resets to the divide-by-four code.
// [R3] Select code zero gives a quarter-rate system clock.
// [R4] Lock flag stays low for the lock interval after a ratio write.
// [R5] Status shows lock flag and missing-oscillator flag to software.
// [R6] Missing oscillator with detection on: limp mode and reset request.
// [R7] A control bit powers the PLL off.
// [R8] Software bypasses the PLL with ratio zero before powering off.
// [R9] Software checks missing-clock status before changing the ratio.
// [R10] Software follows the documented ratio change sequence.
// [R11] Pulse-width, capture and decoder clocks are individually gated.
// [R12] Memory interface, timers, DMA and input logic clocks are gated.
// [R13] Low-power control holds a watchdog wake-from-standby bit.
// [R14] Wake select register picks pins waking from halt and standby.
// [R15] Map bit places pulse-width units legacy (0) or in frame 3 (1).
// [R16] Reset clears memory interface gate, sets timer and input gates.
// [R17] Divider select changes never produce runt clock pulses.
`timescale 1ns/1ps
`default_nettype none
module pcsc_clock_ctrl #(
    parameter int unsigned LOCK_CYC = pcsc_pkg::LOCK_CYCLES,
    parameter int unsigned MISS_CYC = pcsc_pkg::MISS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic crystalInput,
    input wire logic extOscInput,
    input wire logic ratioWr,
    input wire logic [pcsc_pkg::RATIO_W-1:0] ratioIn,
    input wire logic divSelWr,
    input wire logic [1:0] divSelIn,
    input wire logic pllOffIn,
    input wire logic oscDetEnIn,
    input wire logic missClr,
    input wire logic clkEnBWr,
    input wire logic [pcsc_pkg::CLK_EN_B_W-1:0] clkEnBIn,
    input wire logic clkEnCWr,
    input wire logic [pcsc_pkg::CLK_EN_C_W-1:0] clkEnCIn,
    input wire logic lpmWr,
    input wire logic wdWakeIn,
    input wire logic wakeSelWr,
    input wire logic [pcsc_pkg::WAKE_W-1:0] wakeSelIn,
    input wire logic pwmMapWr,
    input wire logic pwmMapIn,
    output logic sysClkEn_q,
    output logic [1:0] post_divider_select_q,
    output logic [pcsc_pkg::RATIO_W-1:0] ratio_q,
    output logic pllLock_q,
    output logic pllOff_q,
    output logic oscMiss_q,
    output logic limpMode_q,
    output logic resetReq_q,
    output logic [pcsc_pkg::CLK_EN_B_W-1:0] clkEnB_q,
    output logic [pcsc_pkg::CLK_EN_C_W-1:0] clkEnC_q,
    output logic wdWake_q,
    output logic [pcsc_pkg::WAKE_W-1:0] wakeSel_q,
    output logic pwmMap_q
);
    // Pin synchronisers; first stage is read only by the second
    logic [1:0] xtalSync1_q, xtalSync1_d;
    logic [1:0] xtalSync2_q, xtalSync2_d;
    logic [1:0] xtalLast_q, xtalLast_d;
    logic [15:0] missCnt_q, missCnt_d;
    logic oscMiss_d, limpMode_d, resetReq_d;
    logic oscEdge;

    // Oscillator watch: any edge on either source restarts the timeout
    always_comb begin
        xtalSync1_d = {extOscInput, crystalInput};
        xtalSync2_d = xtalSync1_q;
        xtalLast_d = xtalSync2_q;
        oscEdge = |(xtalSync2_q ^ xtalLast_q);
        missCnt_d = missCnt_q;
        oscMiss_d = oscMiss_q;
        resetReq_d = 1'b0;
        if (oscEdge || !oscDetEnIn) begin
            missCnt_d = 16'h0000;
        end else if (missCnt_q != MISS_CYC[15:0]) begin
            missCnt_d = missCnt_q + 16'h0001;
        end
        // Set wins over a clear in the same cycle
        if (missClr) begin
            oscMiss_d = 1'b0;
        end
        if (oscDetEnIn && !oscEdge && missCnt_q == MISS_CYC[15:0] - 16'h0001) begin
            oscMiss_d = 1'b1; // see [R6]
            resetReq_d = !oscMiss_q; // see [R6]
        end
        limpMode_d = oscMiss_d; // see [R6]
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            xtalSync1_q <= 2'h0;
            xtalSync2_q <= 2'h0;
            xtalLast_q <= 2'h0;
            missCnt_q <= 16'h0000;
            oscMiss_q <= 1'b0;
            limpMode_q <= 1'b0;
            resetReq_q <= 1'b0;
        end else begin
            xtalSync1_q <= xtalSync1_d;
            xtalSync2_q <= xtalSync2_d;
            xtalLast_q <= xtalLast_d;
            missCnt_q <= missCnt_d;
            oscMiss_q <= oscMiss_d;
            limpMode_q <= limpMode_d;
            resetReq_q <= resetReq_d;
        end
    end

    // PLL ratio, power and lock tracking
    pcsc_pkg::pcsc_lock_e lockSt_q, lockSt_d;
    logic [15:0] lockCnt_q, lockCnt_d;
    logic [pcsc_pkg::RATIO_W-1:0] ratio_d;
    logic pllOff_d, pllLock_d;

    // Ratio writes are dropped in limp mode so recovery is not upset
    always_comb begin
        ratio_d = ratio_q;
        pllOff_d = pllOffIn; // see [R7]
        lockSt_d = lockSt_q;
        lockCnt_d = lockCnt_q;
        if (ratioWr && !oscMiss_q) begin
            ratio_d = ratioIn;
        end
        unique case (lockSt_q)
            pcsc_pkg::PCSC_OFF: begin
                if (!pllOff_q) begin
                    lockSt_d = pcsc_pkg::PCSC_LOCKING;
                    lockCnt_d = 16'h0000;
                end
            end
            pcsc_pkg::PCSC_LOCKING: begin
                lockCnt_d = lockCnt_q + 16'h0001;
                if (lockCnt_q == LOCK_CYC[15:0] - 16'h0001) begin
                    lockSt_d = pcsc_pkg::PCSC_LOCKED; // see [R4]
                end
            end
            pcsc_pkg::PCSC_LOCKED: begin
                lockSt_d = pcsc_pkg::PCSC_LOCKED;
            end
        endcase
        // A new ratio restarts the lock interval
        if (ratioWr && !oscMiss_q && lockSt_q != pcsc_pkg::PCSC_OFF) begin
            lockSt_d = pcsc_pkg::PCSC_LOCKING; // see [R4]
            lockCnt_d = 16'h0000;
        end
        if (pllOff_q) begin
            lockSt_d = pcsc_pkg::PCSC_OFF; // see [R7]
        end
        pllLock_d = (lockSt_d == pcsc_pkg::PCSC_LOCKED); // see [R5]
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ratio_q <= pcsc_pkg::RATIO_BYPASS;
            pllOff_q <= 1'b0;
            lockSt_q <= pcsc_pkg::PCSC_LOCKING;
            lockCnt_q <= 16'h0000;
            pllLock_q <= 1'b0;
        end else begin
            ratio_q <= ratio_d;
            pllOff_q <= pllOff_d;
            lockSt_q <= lockSt_d;
            lockCnt_q <= lockCnt_d;
            pllLock_q <= pllLock_d;
        end
    end

    // Post-divider; the new select is taken only at a period boundary
    logic [1:0] divCnt_q, divCnt_d;
    logic [1:0] post_divider_select_d, divTerm;
    logic [1:0] divAct_q, divAct_d;
    logic sysClkEn_d, divWrap;

    // Software select is shown at once; the active select waits for a wrap
    always_comb begin
        post_divider_select_d = post_divider_select_q;
        if (divSelWr) begin
            post_divider_select_d = divSelIn;
        end
        unique case (divAct_q)
            pcsc_pkg::DIV_SEL_ONE: divTerm = pcsc_pkg::DIV_TERM_ONE; // see [R1]
            pcsc_pkg::DIV_SEL_HALF: divTerm = pcsc_pkg::DIV_TERM_HALF; // see [R1]
            default: divTerm = pcsc_pkg::DIV_TERM_QUARTER; // see [R3]
        endcase
        divWrap = (divCnt_q >= divTerm);
        // Counter and pulse always finish the running period first
        divAct_d = divAct_q;
        if (divWrap) begin
            divCnt_d = 2'h0; // see [R17]
            divAct_d = post_divider_select_q; // see [R17]
        end else begin
            divCnt_d = divCnt_q + 2'h1;
        end
        sysClkEn_d = divWrap; // see [R1]
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            post_divider_select_q <= pcsc_pkg::DIV_SEL_RESET; // see [R2]
            divAct_q <= pcsc_pkg::DIV_SEL_RESET; // see [R2]
            divCnt_q <= 2'h0;
            sysClkEn_q <= 1'b0;
        end else begin
            post_divider_select_q <= post_divider_select_d;
            divAct_q <= divAct_d;
            divCnt_q <= divCnt_d;
            sysClkEn_q <= sysClkEn_d;
        end
    end

    // Clock gates, low-power and map control bits
    logic [pcsc_pkg::CLK_EN_B_W-1:0] clkEnB_d;
    logic [pcsc_pkg::CLK_EN_C_W-1:0] clkEnC_d;
    logic [pcsc_pkg::WAKE_W-1:0] wakeSel_d;
    logic wdWake_d, pwmMap_d;

    always_comb begin
        clkEnB_d = clkEnBWr ? clkEnBIn : clkEnB_q; // see [R11]
        clkEnC_d = clkEnCWr ? clkEnCIn : clkEnC_q; // see [R12]
        wdWake_d = lpmWr ? wdWakeIn : wdWake_q; // see [R13]
        wakeSel_d = wakeSelWr ? wakeSelIn : wakeSel_q; // see [R14]
        pwmMap_d = pwmMapWr ? pwmMapIn : pwmMap_q; // see [R15]
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            clkEnB_q <= pcsc_pkg::CLK_EN_B_RESET;
            clkEnC_q <= pcsc_pkg::CLK_EN_C_RESET; // see [R16]
            wdWake_q <= 1'b0;
            wakeSel_q <= pcsc_pkg::WAKE_SEL_RESET;
            pwmMap_q <= 1'b0;
        end else begin
            clkEnB_q <= clkEnB_d;
            clkEnC_q <= clkEnC_d;
            wdWake_q <= wdWake_d;
            wakeSel_q <= wakeSel_d;
            pwmMap_q <= pwmMap_d;
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_div_quarter: assert property ( // see [R3]
        sysClkEn_q && (divAct_q == pcsc_pkg::DIV_SEL_RESET
            || divAct_q == pcsc_pkg::DIV_SEL_QUARTER) |=> !sysClkEn_q [*3] ##1 sysClkEn_q)
        else $error("quarter divide period wrong");
    a_div_half: assert property ( // see [R1]
        sysClkEn_q && divAct_q == pcsc_pkg::DIV_SEL_HALF |=> !sysClkEn_q ##1 sysClkEn_q)
        else $error("half divide period wrong");
    a_div_one: assert property ( // see [R1]
        divAct_q == pcsc_pkg::DIV_SEL_ONE |=> sysClkEn_q)
        else $error("divide by one missed a pulse");
    a_no_runt: assert property ( // see [R17]
        sysClkEn_q && !$past(sysClkEn_q) && divAct_q != pcsc_pkg::DIV_SEL_ONE |=> !sysClkEn_q)
        else $error("runt clock pulse");
    a_sel_boundary: assert property ( // see [R17]
        divAct_q != $past(divAct_q) |-> sysClkEn_q)
        else $error("divider select changed mid period");
    a_lock_after_ratio: assert property ( // see [R4]
        ratioWr && !oscMiss_q && !pllOff_q && !pllOffIn |=> !pllLock_q)
        else $error("lock flag not dropped on ratio write");
    a_lock_reached: assert property ( // see [R4]
        lockSt_q == pcsc_pkg::PCSC_LOCKING && lockCnt_q == 16'h0000 && !pllOff_q
            ##1 (!ratioWr && !pllOff_q && !pllOffIn) [*8] |-> ##[0:600] pllLock_q)
        else $error("lock flag never set");
    a_off_unlocked: assert property ( // see [R7]
        pllOff_q |=> !pllLock_q)
        else $error("locked while powered off");
    a_miss_reset: assert property ( // see [R6]
        $rose(oscMiss_q) |-> resetReq_q && limpMode_q)
        else $error("missing oscillator without reset");
    a_miss_held: assert property ( // see [R5]
        oscMiss_q && !missClr |=> oscMiss_q)
        else $error("missing flag lost");
    a_gate_write: assert property ( // see [R12]
        clkEnCWr |=> clkEnC_q == $past(clkEnCIn))
        else $error("clock gate not written");
    a_map_write: assert property ( // see [R15]
        pwmMapWr |=> pwmMap_q == $past(pwmMapIn))
        else $error("map bit not written");

    c_lock: cover property ($rose(pllLock_q));
    c_miss: cover property ($rose(oscMiss_q));
    c_div_change: cover property (divSelWr && divSelIn != post_divider_select_q);
    c_pll_off: cover property ($rose(pllOff_q));
endmodule
`default_nettype wire

// [inc/pcsc_pkg.sv]
// Package for the clock generation and system control block.
// Assumes a single 10 MHz system clock; all counts are derived here.
package pcsc_pkg;
    // System clock rate
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Post-divider select codes; codes 0 and 1 both give divide by four
    localparam logic [1:0] DIV_SEL_RESET = 2'h0;
    localparam logic [1:0] DIV_SEL_QUARTER = 2'h1;
    localparam logic [1:0] DIV_SEL_HALF = 2'h2;
    localparam logic [1:0] DIV_SEL_ONE = 2'h3;
    // Divider terminal counts (divide ratio minus one)
    localparam logic [1:0] DIV_TERM_QUARTER = 2'h3;
    localparam logic [1:0] DIV_TERM_HALF = 2'h1;
    localparam logic [1:0] DIV_TERM_ONE = 2'h0;
    // Multiplication ratio; zero means bypass
    localparam int unsigned RATIO_W = 4;
    localparam logic [RATIO_W-1:0] RATIO_BYPASS = 4'h0;
    // Lock interval after a ratio change or power-up of the PLL
    localparam int unsigned LOCK_TIME_NS = 50000;
    localparam int unsigned LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // No input clock edge for this long means the oscillator is missing
    localparam int unsigned MISS_TIME_NS = 2000;
    localparam int unsigned MISS_CYCLES = (MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Control-unit clock gates: six pulse-width, six capture, two decoder
    localparam int unsigned CLK_EN_B_W = 14;
    localparam logic [CLK_EN_B_W-1:0] CLK_EN_B_RESET = 14'h0000;
    // System clock gates
    localparam int unsigned CLK_EN_C_W = 4;
    localparam int unsigned CLK_EN_C_XMEM = 0;
    localparam int unsigned CLK_EN_C_TIMER = 1;
    localparam int unsigned CLK_EN_C_DMA = 2;
    localparam int unsigned CLK_EN_C_GPIN = 3;
    localparam logic [CLK_EN_C_W-1:0] CLK_EN_C_RESET = 4'hA;
    // Wake selection covers pins 0 to 31
    localparam int unsigned WAKE_W = 32;
    localparam logic [WAKE_W-1:0] WAKE_SEL_RESET = 32'h00000000;
    // Lock tracker states
    typedef enum logic [1:0] {PCSC_OFF, PCSC_LOCKING, PCSC_LOCKED} pcsc_lock_e;
endpackage

// [verif/pcsc_osc_model.sv]
// Model of the clock source on the oscillator pins: crystal and external input.
// Assumes the bench turns each source on or off; a stopped pin is tied low.
`timescale 1ns/1ps
`default_nettype none
module pcsc_osc_model (
    input wire logic runX,
    input wire logic runE,
    output logic crystalInput,
    output logic extOscInput
);
    logic oscX;
    logic oscE;
    // Free-running sources, unrelated in phase to the system clock
    initial begin
        oscX = 1'b0;
        forever #37 oscX = ~oscX;
    end
    initial begin
        oscE = 1'b0;
        forever #23 oscE = ~oscE;
    end
    // An unused clock pin is tied low, never left floating
    assign crystalInput = runX ? oscX : 1'b0;
    assign extOscInput = runE ? oscE : 1'b0;
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the clock generation and system control block.
// Assumes short lock and miss counts; inputs change 1 ns after clk_sys rises.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LOCKC = 8;
    localparam int MISSC = 6;
    logic clk_sys, nrst, runX, runE, crystalInput, extOscInput;
    logic ratioWr, divSelWr, pllOffIn, oscDetEnIn, missClr, clkEnBWr, clkEnCWr;
    logic lpmWr, wdWakeIn, wakeSelWr, pwmMapWr, pwmMapIn;
    logic [3:0] ratioIn, clkEnCIn;
    logic [1:0] divSelIn;
    logic [13:0] clkEnBIn;
    logic [31:0] wakeSelIn;
    logic sysClkEn_q, pllLock_q, pllOff_q, oscMiss_q, limpMode_q, resetReq_q, wdWake_q, pwmMap_q;
    logic [1:0] post_divider_select_q;
    logic [3:0] ratio_q, clkEnC_q;
    logic [13:0] clkEnB_q;
    logic [31:0] wakeSel_q;
    int failures = 0;
    int num_checks = 0;
    int n, p, o, s;
    pcsc_osc_model osc_u (.runX(runX), .runE(runE), .crystalInput(crystalInput),
        .extOscInput(extOscInput));
    pcsc_clock_ctrl #(.LOCK_CYC(LOCKC), .MISS_CYC(MISSC)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .crystalInput(crystalInput), .extOscInput(extOscInput), .ratioWr(ratioWr),
        .ratioIn(ratioIn), .divSelWr(divSelWr), .divSelIn(divSelIn), .pllOffIn(pllOffIn),
        .oscDetEnIn(oscDetEnIn), .missClr(missClr), .clkEnBWr(clkEnBWr), .clkEnBIn(clkEnBIn),
        .clkEnCWr(clkEnCWr), .clkEnCIn(clkEnCIn), .lpmWr(lpmWr), .wdWakeIn(wdWakeIn),
        .wakeSelWr(wakeSelWr), .wakeSelIn(wakeSelIn), .pwmMapWr(pwmMapWr), .pwmMapIn(pwmMapIn),
        .sysClkEn_q(sysClkEn_q), .post_divider_select_q(post_divider_select_q), .ratio_q(ratio_q), .pllLock_q(pllLock_q),
        .pllOff_q(pllOff_q), .oscMiss_q(oscMiss_q), .limpMode_q(limpMode_q),
        .resetReq_q(resetReq_q), .clkEnB_q(clkEnB_q), .clkEnC_q(clkEnC_q), .wdWake_q(wdWake_q),
        .wakeSel_q(wakeSel_q), .pwmMap_q(pwmMap_q));
    // 10 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
        num_checks++;
        if (a !== e) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, a, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Period in system cycles that a select code should give
    function automatic int divPer(input int c);
        return (c == 3) ? 1 : (c == 2) ? 2 : 4;
    endfunction
    task automatic wrRatio(input logic [3:0] v);
        ratioIn = v;
        ratioWr = 1'b1;
        tick();
        ratioWr = 1'b0;
    endtask
    task automatic wrDiv(input logic [1:0] v);
        divSelIn = v;
        divSelWr = 1'b1;
        tick();
        divSelWr = 1'b0;
    endtask
    // Cycles from one divided-clock pulse to the next, bounded
    task automatic gap(output int g);
        int w;
        w = 0;
        while (sysClkEn_q !== 1'b1 && w < 10) begin
            tick();
            w++;
        end
        tick();
        g = 1;
        while (sysClkEn_q !== 1'b1 && g < 10) begin
            tick();
            g++;
        end
    endtask
    task automatic waitLock(output int c);
        c = 0;
        while (pllLock_q !== 1'b1 && c < LOCKC + 6) begin
            tick();
            c++;
        end
    endtask
    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {nrst, runE, ratioWr, divSelWr, pllOffIn, oscDetEnIn, missClr, clkEnBWr} = '0;
        {clkEnCWr, lpmWr, wdWakeIn, wakeSelWr, pwmMapWr, pwmMapIn} = '0;
        {ratioIn, clkEnCIn, divSelIn, clkEnBIn, wakeSelIn} = '0;
        runX = 1'b1;
        void'($urandom(60482));
        repeat (10) tick();
        nrst = 1'b1;
        tick();
        chk(post_divider_select_q, 0, "div reset");
        chk(clkEnC_q, (1 << 1) | (1 << 3), "gate reset");
        gap(p);
        chk(p, 4, "reset period");
        $display("reset test done");
        // Select changes, each code in turn then random: each gap is the old or the new period
        o = 4;
        for (int i = 0; i < 8; i++) begin
            s = (i < 4) ? i : $urandom % 4;
            wrDiv(s[1:0]);
            for (int k = 0; k < 3; k++) begin
                gap(p);
                chk(p == o || p == divPer(s), 1, "runt period");
            end
            gap(p);
            chk(p, divPer(s), "period");
            o = divPer(s);
        end
        $display("divider test done");
        // Ratio change in the safe order, second write restarting lock
        chk(oscMiss_q, 0, "miss before ratio");
        oscDetEnIn = 1'b0;
        wrDiv(2'h0);
        wrRatio(4'h1 + 4'($urandom % 15));
        repeat (3) tick();
        s = 1 + $urandom % 15;
        wrRatio(s[3:0]);
        chk(ratio_q, s, "ratio");
        chk(pllLock_q, 0, "lock low");
        waitLock(n);
        chk(n >= LOCKC && n <= LOCKC + 1, 1, "lock interval");
        oscDetEnIn = 1'b1;
        wrDiv(2'h3);
        $display("lock test done");
        // Power off only after bypass
        wrRatio(4'h0);
        pllOffIn = 1'b1;
        repeat (LOCKC + 3) tick();
        chk({pllOff_q, pllLock_q}, 2'b10, "pll off");
        pllOffIn = 1'b0;
        waitLock(n);
        chk(n >= LOCKC && n <= LOCKC + 2, 1, "relock");
        $display("power test done");
        // Both sources stop with detection on
        runX = 1'b0;
        n = 0;
        while (oscMiss_q !== 1'b1 && n < MISSC + 10) begin
            tick();
            n++;
        end
        chk(n >= MISSC && n <= MISSC + 6, 1, "miss delay");
        chk({limpMode_q, resetReq_q}, 2'b11, "limp and reset");
        tick();
        chk(resetReq_q, 0, "reset pulse");
        wrRatio(4'h5);
        chk(ratio_q, 0, "ratio refused");
        runE = 1'b1;
        repeat (4) tick();
        missClr = 1'b1;
        tick();
        missClr = 1'b0;
        tick();
        chk({oscMiss_q, limpMode_q}, 2'b00, "miss clear");
        oscDetEnIn = 1'b0;
        runE = 1'b0;
        repeat (MISSC * 3) tick();
        chk(oscMiss_q, 0, "detect off");
        runX = 1'b1;
        $display("missing clock test done");
        // Gates, wake bits and map bit, back to back
        {clkEnBWr, clkEnCWr, lpmWr, wakeSelWr, pwmMapWr} = '1;
        for (int i = 0; i < 16; i++) begin
            clkEnBIn = 14'($urandom);
            clkEnCIn = 4'($urandom);
            wdWakeIn = 1'($urandom);
            wakeSelIn = $urandom;
            pwmMapIn = 1'($urandom);
            tick();
            chk(clkEnB_q, clkEnBIn, "gates b");
            chk(clkEnC_q, clkEnCIn, "gates c");
            chk(wdWake_q, wdWakeIn, "wd wake");
            chk(wakeSel_q, wakeSelIn, "wake sel");
            chk(pwmMap_q, pwmMapIn, "map");
        end
        {clkEnBWr, clkEnCWr, lpmWr, wakeSelWr, pwmMapWr} = '0;
        clkEnCIn = ~clkEnCIn;
        tick();
        // Cast keeps the inversion at four bits before widening
        chk(clkEnC_q, 4'(~clkEnCIn), "gates hold");
        clkEnCIn = 4'h1;
        nrst = 1'b0;
        repeat (3) tick();
        nrst = 1'b1;
        tick();
        chk(clkEnC_q, (1 << 1) | (1 << 3), "gate reset again");
        $display("register test done");
        print_verdict();
    end
endmodule
`default_nettype wire
